/* File: src/ppfs_cfg.svh */
`ifndef PPFS_CFG_SVH
`define PPFS_CFG_SVH
`define PPFS_NPIN 7
`define PPFS_NSLOT 18
`define PPFS_IDX_W 5
`define PPFS_SEL_W 6
`define PPFS_AW 5
`define PPFS_DW 32
`define PPFS_OFS_P00 5'h00
`define PPFS_OFS_P01 5'h04
`define PPFS_OFS_P02 5'h08
`define PPFS_OFS_P11 5'h0c
`define PPFS_OFS_P14 5'h10
`define PPFS_OFS_P15 5'h14
`define PPFS_OFS_P17 5'h18
`define PPFS_OFS_STAT 5'h1c
`define PPFS_SEL_RESET 6'h00
`define PPFS_HIZ_CODE 6'h00
`define PPFS_CODE_SLAVE 6'h27
`define PPFS_CODE_TSYNC 6'h11
`define PPFS_PIN_P11 3'h3
`define PPFS_STAT_SLAVE_BIT 8
`define PPFS_STAT_TSYNC_BIT 9
`endif

/* File: src/ppfs_pkg.sv */
`include "ppfs_cfg.svh"
package ppfs_pkg;
	// Drive from the peripherals, one slot per listed function of a pin
	typedef struct packed {
		logic [`PPFS_NSLOT-1:0] out;
		logic [`PPFS_NSLOT-1:0] oe;
	} ppfs_drive_type;
	typedef struct packed {
		logic hit;
		logic [`PPFS_IDX_W-1:0] idx;
	} ppfs_slot_type;
	typedef logic [`PPFS_SEL_W-1:0] ppfs_code_type;
	// Slot k of pin p answers to code ppfs_code_tab[p][k]; zero entries are padding
	localparam ppfs_code_type PPFS_CODE_TAB [`PPFS_NPIN][`PPFS_NSLOT] = '{
		'{6'h05, 6'h0a, 6'h17, 6'h1b, 6'h27, 6'h00, 6'h00, 6'h00, 6'h00,
			6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
		'{6'h05, 6'h0a, 6'h17, 6'h1b, 6'h27, 6'h00, 6'h00, 6'h00, 6'h00,
			6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
		'{6'h05, 6'h0a, 6'h17, 6'h27, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
			6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
		'{6'h01, 6'h05, 6'h0a, 6'h11, 6'h25, 6'h27, 6'h00, 6'h00, 6'h00,
			6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
		'{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0b, 6'h10, 6'h12,
			6'h1e, 6'h25, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
		'{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0a, 6'h0b, 6'h10,
			6'h17, 6'h1c, 6'h1e, 6'h27, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
		'{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
			6'h0a, 6'h0b, 6'h0f, 6'h11, 6'h17, 6'h1a, 6'h1c, 6'h1e, 6'h27}
	};
endpackage

/* File: src/ppfs_top.sv */
`timescale 1ns/10ps
`include "ppfs_cfg.svh"
module ppfs_top
	import ppfs_pkg::*;
#(
	parameter bit HAS_SLAVE_CTRL = 1'b1,
	parameter bit HAS_TIMESYNC = 1'b1
) (
	input wire logic CLK, // 200 MHz peripheral bus clock
	input wire logic NRST, // Asynchronous system reset
	input wire logic CE, // Clock enable, freezes all state when low
	input wire logic [`PPFS_AW-1:0] AVS_ADDRESS, // Byte address
	input wire logic AVS_READ, // Read request
	input wire logic AVS_WRITE, // Write request
	input wire logic [`PPFS_DW-1:0] AVS_WRITEDATA, // Write data
	input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
	output logic [`PPFS_DW-1:0] AVS_READDATA, // Read data
	output logic AVS_WAITREQUEST, // Stall until answer
	input wire logic [`PPFS_NPIN-1:0] PIN_IN, // Pin levels from the pads
	output wire [`PPFS_NPIN-1:0] PIN_OUT, // Pin output levels
	output wire [`PPFS_NPIN-1:0] PIN_OE, // Pin output enables
	input wire ppfs_drive_type PERIPH_DRV [`PPFS_NPIN], // Peripheral drive per slot
	output wire [`PPFS_NSLOT-1:0] PERIPH_IN [`PPFS_NPIN] // Pin level to selected slot
);
	ppfs_code_type func_r [`PPFS_NPIN];
	logic wait_r;
	logic [`PPFS_DW-1:0] rdata_r;
	wire [`PPFS_NPIN-1:0] active;
	logic bus_req;
	logic wr_take;

	// Unlisted codes find no slot and leave the pin undriven
	function automatic ppfs_slot_type slot_of(input int pin, input ppfs_code_type code);
		ppfs_slot_type s;
		s = '0;
		for (int k = 0; k < `PPFS_NSLOT; k++) begin
			if (code != `PPFS_HIZ_CODE && PPFS_CODE_TAB[pin][k] == code) begin
				s.hit = 1'b1;
				s.idx = `PPFS_IDX_W'(k);
			end
		end
		if (code == `PPFS_CODE_SLAVE && !HAS_SLAVE_CTRL) begin
			s.hit = 1'b0;
		end
		if (pin == int'(`PPFS_PIN_P11) && code == `PPFS_CODE_TSYNC && !HAS_TIMESYNC) begin
			s.hit = 1'b0;
		end
		return s;
	endfunction

	function automatic logic [`PPFS_DW-1:0] read_word(input logic [`PPFS_AW-1:0] a);
		logic [`PPFS_DW-1:0] w;
		w = '0;
		unique case (a)
			`PPFS_OFS_P00: w[`PPFS_SEL_W-1:0] = func_r[0];
			`PPFS_OFS_P01: w[`PPFS_SEL_W-1:0] = func_r[1];
			`PPFS_OFS_P02: w[`PPFS_SEL_W-1:0] = func_r[2];
			`PPFS_OFS_P11: w[`PPFS_SEL_W-1:0] = func_r[3];
			`PPFS_OFS_P14: w[`PPFS_SEL_W-1:0] = func_r[4];
			`PPFS_OFS_P15: w[`PPFS_SEL_W-1:0] = func_r[5];
			`PPFS_OFS_P17: w[`PPFS_SEL_W-1:0] = func_r[6];
			`PPFS_OFS_STAT: begin
				w[`PPFS_NPIN-1:0] = active;
				w[`PPFS_STAT_SLAVE_BIT] = HAS_SLAVE_CTRL;
				w[`PPFS_STAT_TSYNC_BIT] = HAS_TIMESYNC;
			end
			default: w = '0;
		endcase
		return w;
	endfunction

	assign bus_req = AVS_READ || AVS_WRITE;
	assign wr_take = AVS_WRITE && !wait_r && AVS_BYTEENABLE[0];

	// One wait state: answer in the cycle after the request is seen
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wait_r <= 1'b1;
		end else if (CE) begin
			wait_r <= !(bus_req && wait_r);
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rdata_r <= '0;
		end else if (CE && AVS_READ && wait_r) begin
			rdata_r <= read_word(AVS_ADDRESS);
		end
	end

	// Only byte lane 0 carries the select field; other lanes read zero
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < `PPFS_NPIN; i++) begin
				func_r[i] <= `PPFS_SEL_RESET;
			end
		end else if (CE && wr_take) begin
			unique case (AVS_ADDRESS)
				`PPFS_OFS_P00: func_r[0] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				`PPFS_OFS_P01: func_r[1] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				`PPFS_OFS_P02: func_r[2] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				`PPFS_OFS_P11: func_r[3] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				`PPFS_OFS_P14: func_r[4] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				`PPFS_OFS_P15: func_r[5] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				`PPFS_OFS_P17: func_r[6] <= AVS_WRITEDATA[`PPFS_SEL_W-1:0];
				default: ;
			endcase
		end
	end

	assign AVS_WAITREQUEST = wait_r;
	assign AVS_READDATA = rdata_r;

	for (genvar p = 0; p < `PPFS_NPIN; p++) begin : g_pin
		logic [1:0] sync_r;
		logic out_r;
		logic oe_r;
		logic [`PPFS_NSLOT-1:0] in_r;
		ppfs_slot_type sel;

		assign sel = slot_of(p, func_r[p]);
		assign active[p] = sel.hit;

		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				sync_r <= 2'h0;
			end else if (CE) begin
				sync_r <= {sync_r[0], PIN_IN[p]};
			end
		end

		// Registered mux adds a cycle but keeps every pad signal glitch free
		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				out_r <= 1'b0;
				oe_r <= 1'b0;
			end else if (CE) begin
				out_r <= sel.hit && PERIPH_DRV[p].out[sel.idx];
				oe_r <= sel.hit && PERIPH_DRV[p].oe[sel.idx];
			end
		end

		// Unselected peripheral inputs see a quiet low
		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				in_r <= '0;
			end else if (CE) begin
				in_r <= '0;
				if (sel.hit) begin
					in_r[sel.idx] <= sync_r[1];
				end
			end
		end

		assign PIN_OUT[p] = out_r;
		assign PIN_OE[p] = oe_r;
		assign PERIPH_IN[p] = in_r;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_p00_hiz_idle: assert property (CE && func_r[0] == `PPFS_HIZ_CODE
		|=> !PIN_OE[0] && PERIPH_IN[0] == '0)
		else $error("pin00 not idle at code zero");
	a_p00_timer_reset: assert property (CE && func_r[0] == PPFS_CODE_TAB[0][0]
		|=> PERIPH_IN[0][0] == $past(g_pin[0].sync_r[1]))
		else $error("pin00 timer reset input not routed");
	a_p00_serial_tx: assert property (CE && func_r[0] == PPFS_CODE_TAB[0][1]
		|=> PIN_OE[0] == $past(PERIPH_DRV[0].oe[1]) && PIN_OUT[0] == $past(PERIPH_DRV[0].out[1]))
		else $error("pin00 transmit not driven");
	a_p01_count_clock: assert property (CE && func_r[1] == PPFS_CODE_TAB[1][0]
		|=> $onehot0(PERIPH_IN[1]) && PERIPH_IN[1][0] == $past(g_pin[1].sync_r[1]))
		else $error("pin01 count clock not routed");
	a_p02_sync_delay: assert property ((CE && func_r[2] == PPFS_CODE_TAB[2][1])[*4]
		|-> PERIPH_IN[2][1] == $past(PIN_IN[2], 3))
		else $error("pin02 clock input delay wrong");
	a_slave_variant: assert property (CE && func_r[1] == `PPFS_CODE_SLAVE
		|=> PIN_OE[1] == (HAS_SLAVE_CTRL && $past(PERIPH_DRV[1].oe[4])))
		else $error("slave code gating wrong on pin01");
	a_p11_panel_data: assert property (CE && func_r[3] == PPFS_CODE_TAB[3][4]
		|=> PIN_OUT[3] == $past(PERIPH_DRV[3].out[4]))
		else $error("pin11 panel data not driven");
	a_p11_timesync: assert property (CE && func_r[3] == `PPFS_CODE_TSYNC
		|=> PIN_OE[3] == (HAS_TIMESYNC && $past(PERIPH_DRV[3].oe[3])))
		else $error("pin11 time-sync gating wrong");
	// Same-cycle check: the select may be rewritten on the very next edge
	a_p14_low_codes: assert property (CE && func_r[4] >= PPFS_CODE_TAB[4][0]
		&& func_r[4] <= PPFS_CODE_TAB[4][5]
		|-> g_pin[4].sel.hit && g_pin[4].sel.idx == 5'(func_r[4] - 6'h01))
		else $error("pin14 low codes out of order");
	a_p14_can_tx: assert property (CE && func_r[4] == PPFS_CODE_TAB[4][7]
		|=> PIN_OE[4] == $past(PERIPH_DRV[4].oe[7]))
		else $error("pin14 CAN transmit not driven");
	a_p15_can_rx: assert property (CE && func_r[5] == PPFS_CODE_TAB[5][8]
		|=> $onehot0(PERIPH_IN[5]) && PERIPH_IN[5][8] == $past(g_pin[5].sync_r[1]))
		else $error("pin15 CAN receive not routed");
	a_p15_run_led: assert property (CE && func_r[5] == `PPFS_CODE_SLAVE
		|=> PIN_OUT[5] == (HAS_SLAVE_CTRL && $past(PERIPH_DRV[5].out[12])))
		else $error("pin15 run LED gating wrong");
	a_p17_conv_trigger: assert property (CE && func_r[6] == PPFS_CODE_TAB[6][8]
		|=> PERIPH_IN[6][8] == $past(g_pin[6].sync_r[1]))
		else $error("pin17 converter trigger not routed");
	a_p17_pwm_io: assert property (CE && func_r[6] == PPFS_CODE_TAB[6][16]
		|=> PIN_OE[6] == $past(PERIPH_DRV[6].oe[16]))
		else $error("pin17 pwm not driven");
	a_bus_one_wait: assert property (CE && bus_req && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST)
		else $error("bus answer late");
	a_bus_write_lands: assert property (CE && wr_take && AVS_ADDRESS == `PPFS_OFS_P00
		|=> func_r[0] == $past(AVS_WRITEDATA[`PPFS_SEL_W-1:0]))
		else $error("write to pin00 select lost");

	// More listed functions: an input and an output on pins 00 to 15, two outputs on pin17, plus the slave code on pins 00, 02, 11 and 15
	a_p00_audio_clock: assert property (CE && func_r[0] == PPFS_CODE_TAB[0][2]
		|=> PERIPH_IN[0][2] == $past(g_pin[0].sync_r[1]))
		else $error("pin00 audio clock not routed");
	a_p00_quad_line2: assert property (CE && func_r[0] == PPFS_CODE_TAB[0][3]
		|=> PIN_OE[0] == $past(PERIPH_DRV[0].oe[3]))
		else $error("pin00 quad line not driven");
	a_p01_serial_rx: assert property (CE && func_r[1] == PPFS_CODE_TAB[1][1]
		|=> PERIPH_IN[1][1] == $past(g_pin[1].sync_r[1]))
		else $error("pin01 serial receive not routed");
	a_p01_quad_line3: assert property (CE && func_r[1] == PPFS_CODE_TAB[1][3]
		|=> PIN_OUT[1] == $past(PERIPH_DRV[1].out[3]))
		else $error("pin01 quad line not driven");
	a_p02_count_clock: assert property (CE && func_r[2] == PPFS_CODE_TAB[2][0]
		|=> PERIPH_IN[2][0] == $past(g_pin[2].sync_r[1]))
		else $error("pin02 count clock not routed");
	a_p02_bit_clock: assert property (CE && func_r[2] == PPFS_CODE_TAB[2][2]
		|=> PIN_OE[2] == $past(PERIPH_DRV[2].oe[2]))
		else $error("pin02 bit clock not driven");
	a_p02_slave_led: assert property (CE && func_r[2] == `PPFS_CODE_SLAVE
		|=> PIN_OE[2] == (HAS_SLAVE_CTRL && $past(PERIPH_DRV[2].oe[3])))
		else $error("slave code gating wrong on pin02");
	a_p00_slave_latch: assert property (CE && func_r[0] == `PPFS_CODE_SLAVE
		|=> PIN_OE[0] == (HAS_SLAVE_CTRL && $past(PERIPH_DRV[0].oe[4])))
		else $error("slave code gating wrong on pin00");
	a_p11_capture_in: assert property (CE && func_r[3] == PPFS_CODE_TAB[3][0]
		|=> PERIPH_IN[3][0] == $past(g_pin[3].sync_r[1]))
		else $error("pin11 capture input not routed");
	a_p11_serial_clock: assert property (CE && func_r[3] == PPFS_CODE_TAB[3][2]
		|=> PIN_OE[3] == $past(PERIPH_DRV[3].oe[2]))
		else $error("pin11 serial clock not driven");
	a_p11_slave_sync: assert property (CE && func_r[3] == `PPFS_CODE_SLAVE
		|=> PIN_OE[3] == (HAS_SLAVE_CTRL && $past(PERIPH_DRV[3].oe[5])))
		else $error("pin11 slave sync gating wrong");
	a_p14_pixel_clock: assert property (CE && func_r[4] == PPFS_CODE_TAB[4][10]
		|=> PIN_OUT[4] == $past(PERIPH_DRV[4].out[10]))
		else $error("pin14 pixel clock not driven");
	a_p14_overcurrent: assert property (CE && func_r[4] == PPFS_CODE_TAB[4][8]
		|=> PERIPH_IN[4][8] == $past(g_pin[4].sync_r[1]))
		else $error("pin14 overcurrent input not routed");
	a_p15_word_clock: assert property (CE && func_r[5] == PPFS_CODE_TAB[5][9]
		|=> PIN_OE[5] == $past(PERIPH_DRV[5].oe[9]))
		else $error("pin15 word clock not driven");
	a_p15_pixel_data: assert property (CE && func_r[5] == PPFS_CODE_TAB[5][10]
		|=> PERIPH_IN[5][10] == $past(g_pin[5].sync_r[1]))
		else $error("pin15 pixel data not routed");
	a_p17_twowire: assert property (CE && func_r[6] == PPFS_CODE_TAB[6][11]
		|=> PIN_OE[6] == $past(PERIPH_DRV[6].oe[11]))
		else $error("pin17 twowire data not driven");
	a_p17_sdcard: assert property (CE && func_r[6] == PPFS_CODE_TAB[6][14]
		|=> PIN_OUT[6] == $past(PERIPH_DRV[6].out[14]))
		else $error("pin17 sdcard data not driven");
	a_p15_slave_run: assert property (CE && func_r[5] == `PPFS_CODE_SLAVE
		|=> PIN_OE[5] == (HAS_SLAVE_CTRL && $past(PERIPH_DRV[5].oe[12])))
		else $error("pin15 run LED enable gating wrong");

	// An unlisted or gated code must leave the pad and every slot quiet
	a_unlisted_quiet: assert property (CE && !g_pin[4].sel.hit
		|=> !PIN_OE[4] && !PIN_OUT[4] && PERIPH_IN[4] == '0)
		else $error("pin14 not quiet without a function");

	// Bus side: one-cycle answer, read data from the field, refused lanes
	a_bus_wait_back: assert property (CE && !AVS_WAITREQUEST
		|=> AVS_WAITREQUEST)
		else $error("answer stood longer than one cycle");
	a_bus_read_data: assert property (CE && AVS_READ && AVS_WAITREQUEST
		&& AVS_ADDRESS == `PPFS_OFS_P00
		|=> AVS_READDATA == `PPFS_DW'($past(func_r[0])))
		else $error("pin00 select read back wrong");
	a_bus_read_status: assert property (CE && AVS_READ && AVS_WAITREQUEST
		&& AVS_ADDRESS == `PPFS_OFS_STAT
		|=> AVS_READDATA[`PPFS_NPIN-1:0] == $past(active))
		else $error("status active bits wrong");
	a_bus_lane_refused: assert property (CE && AVS_WRITE && !AVS_WAITREQUEST
		&& !AVS_BYTEENABLE[0]
		|=> $stable(func_r[0]) && $stable(func_r[2]) && $stable(func_r[6]))
		else $error("write without lane 0 changed a select");

	c_audio_clock: cover property (CE && func_r[0] == PPFS_CODE_TAB[0][2]);
	c_run_led: cover property (CE && func_r[5] == `PPFS_CODE_SLAVE);
	c_write_taken: cover property (CE && wr_take);
	c_read_status: cover property (CE && AVS_READ && !wait_r && AVS_ADDRESS == `PPFS_OFS_STAT);
	c_timesync_sel: cover property (CE && func_r[3] == `PPFS_CODE_TSYNC);
endmodule

/* File: test/ppfs_periph_model.sv */
`timescale 1ns/10ps
`include "ppfs_cfg.svh"
module ppfs_periph_model
	import ppfs_pkg::*;
(
	input wire logic [`PPFS_NSLOT-1:0] level, // Slots that drive, and drive high
	output ppfs_drive_type drv [`PPFS_NPIN] // Drive seen by the pin mux
);
	// An idle slot also holds its data low, so a wrong slot or a lost enable shows
	always_comb begin
		for (int p = 0; p < `PPFS_NPIN; p++) begin
			drv[p].out = level;
			drv[p].oe = level;
		end
	end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`include "ppfs_cfg.svh"
module tb_top
	import ppfs_pkg::*;
();
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic [6:0] pin_in = 7'h00;
	logic [17:0] level = 18'h00000;
	logic [31:0] rdata, rdata_v;
	logic waitreq, waitreq_v;
	logic [6:0] pout, poe, pout_v, poe_v;
	logic [17:0] sel [7];
	logic [17:0] sel_v [7];
	ppfs_drive_type drv [7];
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	// Listed codes per pin in slot order, 6'h00 closes each pin
	localparam logic [5:0] CODES [69] = '{6'h05, 6'h0a, 6'h17, 6'h1b, 6'h27, 6'h00,
		6'h05, 6'h0a, 6'h17, 6'h1b, 6'h27, 6'h00, 6'h05, 6'h0a, 6'h17, 6'h27, 6'h00,
		6'h01, 6'h05, 6'h0a, 6'h11, 6'h25, 6'h27, 6'h00, 6'h01, 6'h02, 6'h03, 6'h04,
		6'h05, 6'h06, 6'h0b, 6'h10, 6'h12, 6'h1e, 6'h25, 6'h00, 6'h01, 6'h02, 6'h03,
		6'h04, 6'h05, 6'h06, 6'h0a, 6'h0b, 6'h10, 6'h17, 6'h1c, 6'h1e, 6'h27, 6'h00,
		6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b,
		6'h0f, 6'h11, 6'h17, 6'h1a, 6'h1c, 6'h1e, 6'h27, 6'h00};
	always #2.5 clk = ~clk;
	ppfs_top dut_u (.CLK(clk), .NRST(nrst), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe),
		.PERIPH_DRV(drv), .PERIPH_IN(sel));
	// Variant without the slave controller and time-sync unit
	ppfs_top #(.HAS_SLAVE_CTRL(1'b0), .HAS_TIMESYNC(1'b0)) dut_v (.CLK(clk), .NRST(nrst),
		.CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata_v), .AVS_WAITREQUEST(waitreq_v),
		.PIN_IN(pin_in), .PIN_OUT(pout_v), .PIN_OE(poe_v), .PERIPH_DRV(drv), .PERIPH_IN(sel_v));
	ppfs_periph_model peri_u (.level(level), .drv(drv));
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] e, output logic [31:0] q, output logic [31:0] qv);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= d;
		be <= e;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		qv = rdata_v;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic t_reset();
		logic [31:0] q, qv;
		for (int p = 0; p < 7; p++) begin
			bus(1'b0, 5'(p * 4), 32'h0, 4'hf, q, qv);
			chk("reset select", 32'h0, q);
		end
		chk("reset enables", 32'h0, 32'(poe));
		bus(1'b1, 5'h1c, 32'hffffffff, 4'hf, q, qv);
		bus(1'b0, 5'h1c, 32'h0, 4'hf, q, qv);
		chk("status", 32'h300, q);
		chk("variant status", 32'h0, qv);
	endtask
	task automatic probe(input int p, input int k, input logic gate);
		level <= 18'h1 << k;
		pin_in <= 7'h7f;
		repeat (5) @(posedge clk);
		chk("pin", 32'({2'b11, 18'h1 << k}), 32'({pout[p], poe[p], sel[p]}));
		chk("variant pin", gate ? 32'h0 : 32'({2'b11, 18'h1 << k}),
			32'({pout_v[p], poe_v[p], sel_v[p]}));
		level <= ~(18'h1 << k);
		pin_in <= 7'h00;
		repeat (5) @(posedge clk);
		chk("pin off", 32'h0, 32'({pout[p], poe[p], sel[p]}));
	endtask
	task automatic t_codes();
		logic [31:0] q, qv;
		int p;
		int k;
		p = 0;
		k = 0;
		for (int i = 0; i < 69; i++) begin
			if (CODES[i] == 6'h00) begin
				bus(1'b1, 5'(p * 4), 32'h0, 4'hf, q, qv);
				level <= 18'h3ffff;
				repeat (3) @(posedge clk);
				chk("hi-z enables", 32'h0, 32'(poe));
				p++;
				k = 0;
			end else begin
				bus(1'b1, 5'(p * 4), 32'(CODES[i]), 4'hf, q, qv);
				bus(1'b0, 5'(p * 4), 32'h0, 4'hf, q, qv);
				chk("select readback", 32'(CODES[i]), q);
				// Slave code everywhere, and time-sync on pin11 (p == 3), vanish in the variant
				probe(p, k, CODES[i] == 6'h27 || (p == 3 && CODES[i] == 6'h11));
				k++;
			end
		end
	endtask
	task automatic t_refuse();
		logic [31:0] q, qv;
		for (int p = 2; p < 7; p++) begin
			bus(1'b1, 5'(p * 4), 32'h1b, 4'hf, q, qv);
		end
		bus(1'b1, 5'h08, 32'h05, 4'he, q, qv);
		bus(1'b0, 5'h08, 32'h0, 4'hf, q, qv);
		chk("unlisted kept", 32'h1b, q);
		level <= 18'h3ffff;
		pin_in <= 7'h7f;
		repeat (5) @(posedge clk);
		chk("unlisted enables", 32'h0, 32'(poe));
		for (int p = 2; p < 7; p++) begin
			chk("unlisted input", 32'h0, 32'(sel[p]));
		end
		bus(1'b0, 5'h1c, 32'h0, 4'hf, q, qv);
		chk("status unlisted", 32'h300, q);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_codes();
		t_refuse();
		results();
	end
endmodule
